//--- logic/timing_card_config_regs.sv
// Configuration register slice of a timing-card synchronizer: input
// formats, host port select status, synthesizer rates, output enables
// and main loop options.
// Assumes a processor port synchronous to ref_clk; strap and select
// pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "timing_cfg_regs.svh"

module timing_card_config_regs (
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    input  wire logic [7:0]                  cpu_addr,
    input  wire timing_cfg_pkg::byte_t       cpu_wdata,
    input  wire logic                        cpu_wr_en,
    input  wire logic                        cpu_rd_en,
    output logic      [7:0]                  cpu_rdata,
    input  wire logic [2:0]                  host_port_select_pins,
    input  wire logic                        network_family_strap,
    input  wire logic                        primary_backup_strap,
    input  wire logic                        main_pll_locked,
    input  wire logic                        main_freq_at_limit,
    input  wire logic                        phase_detector_test_override,
    output logic      [2:0]                  host_port_control_reg,
    output logic                             input1_format_sel,
    output logic                             diff_input_b_format,
    output logic                             diff_input_a_format,
    output timing_cfg_pkg::rate_khz_t        synth_a_rate_khz,
    output timing_cfg_pkg::rate_khz_t        synth_b_rate_khz,
    output logic                             composite_out_tone_en,
    output logic                             composite_out_frame_dis,
    output logic                             diff_out_a_en,
    output logic                             diff_out_b_en,
    output timing_cfg_pkg::bandwidth_e       main_bw_sel,
    output logic                             integral_freeze,
    output logic                             current_freq_readback_hold,
    output timing_cfg_pkg::phase_det_e       phase_detector_mode
);
    import timing_cfg_pkg::*;

    // Pin synchronisers; not reset so the strap levels are valid while
    // resetn is low and can be captured then
    logic [2:0] sel_meta_q;
    logic [2:0] sel_sync_q;
    logic       fam_meta_q;
    logic       fam_sync_q;
    logic       prim_meta_q;
    logic       prim_sync_q;

    always_ff @(posedge ref_clk) begin
        sel_meta_q  <= host_port_select_pins;
        sel_sync_q  <= sel_meta_q;
        fam_meta_q  <= network_family_strap;
        fam_sync_q  <= fam_meta_q;
        prim_meta_q <= primary_backup_strap;
        prim_sync_q <= prim_meta_q;
    end

    // Stored registers
    logic [2:0] in_fmt_q;
    byte_t      family_q;
    byte_t      mult_q;
    byte_t      out_fmt_q;
    byte_t      loop_q;
    logic [2:0] port_ctrl_q;
    rate_khz_t  rate_a_q;
    rate_khz_t  rate_b_q;
    rate_khz_t  rate_a_d;
    rate_khz_t  rate_b_d;
    byte_t      rdata_q;
    byte_t      rdata_d;

    // Address decode
    wire hit_in_fmt  = cpu_addr == `ADDR_INPUT_FORMAT;
    wire hit_status  = cpu_addr == `ADDR_PORT_STATUS;
    wire hit_family  = cpu_addr == `ADDR_SYNTH_FAMILY;
    wire hit_mult    = cpu_addr == `ADDR_SYNTH_MULT;
    wire hit_out_fmt = cpu_addr == `ADDR_OUTPUT_FORMAT;
    wire hit_loop    = cpu_addr == `ADDR_DPLL_LOOP;

    wire wr_in_fmt   = cpu_wr_en && hit_in_fmt;
    wire wr_family   = cpu_wr_en && hit_family;
    wire wr_mult     = cpu_wr_en && hit_mult;
    wire wr_out_fmt  = cpu_wr_en && hit_out_fmt;
    wire wr_loop     = cpu_wr_en && hit_loop;

    // Input format bits; the differential ones are storage only
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            in_fmt_q <= 3'(`RST_INPUT_FORMAT);
        end else if (wr_in_fmt) begin
            in_fmt_q <= cpu_wdata[2:0];
        end
    end

    // Host port type latches the pins only while reset is low, then
    // holds; later pin changes reach software through status only
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            port_ctrl_q <= sel_sync_q;
        end
    end

    // Synthesizer family register; the family bits follow the strap
    // during reset rather than a fixed value
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            family_q                <= `RST_SYNTH_FAMILY;
            family_q[`BIT_B_FAMILY] <= fam_sync_q;
            family_q[`BIT_A_FAMILY] <= fam_sync_q;
        end else if (wr_family) begin
            family_q <= cpu_wdata;
        end
    end

    // Remaining configuration bytes, reserved bits kept as written
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            mult_q    <= `RST_SYNTH_MULT;
            out_fmt_q <= `RST_OUTPUT_FORMAT;
            loop_q    <= `RST_DPLL_LOOP;
        end else begin
            if (wr_mult) begin
                mult_q <= cpu_wdata;
            end
            if (wr_out_fmt) begin
                out_fmt_q <= cpu_wdata;
            end
            if (wr_loop) begin
                loop_q <= cpu_wdata;
            end
        end
    end

    // Synthesizer rates: family picks the base, multiple shifts it by
    // zero to three places; the alternate bit overrides synthesizer B
    wire [1:0]  mult_a = mult_q[`MSB_A_MULT:`LSB_A_MULT];
    wire [1:0]  mult_b = mult_q[`MSB_B_MULT:`LSB_B_MULT];
    wire        fam_a  = family_q[`BIT_A_FAMILY];
    wire        fam_b  = family_q[`BIT_B_FAMILY];
    wire        alt_b  = family_q[`BIT_B_ALT];
    wire [14:0] base_a = fam_a ? `RATE_SONET_KHZ : `RATE_SDH_KHZ;
    wire [14:0] base_b = fam_b ? `RATE_SONET_KHZ : `RATE_SDH_KHZ;

    always_comb begin
        rate_a_d = base_a << mult_a;
        rate_b_d = alt_b ? `RATE_ALT_KHZ : (base_b << mult_b);
    end

    // Rates are registered so the outputs come from flip-flops
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rate_a_q <= '0;
            rate_b_q <= '0;
        end else begin
            rate_a_q <= rate_a_d;
            rate_b_q <= rate_b_d;
        end
    end

    // Read mux; unmapped offsets read zero, status upper bits zero
    always_comb begin
        rdata_d = 8'h00;
        if (hit_in_fmt) begin
            rdata_d = {5'h00, in_fmt_q};
        end else if (hit_status) begin
            rdata_d = {5'h00, sel_sync_q};
        end else if (hit_family) begin
            rdata_d = family_q;
        end else if (hit_mult) begin
            rdata_d = mult_q;
        end else if (hit_out_fmt) begin
            rdata_d = out_fmt_q;
        end else if (hit_loop) begin
            rdata_d = loop_q;
        end
    end

    // Read data is captured on the read strobe and held after it
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (cpu_rd_en) begin
            rdata_q <= rdata_d;
        end
    end

    // Loop option decode; slave mode ignores the auto bit entirely
    wire auto_bw    = loop_q[`BIT_AUTO_BW];
    wire limit_en   = loop_q[`BIT_LIMIT_EN];
    wire want_acq   = !prim_sync_q || (auto_bw && !main_pll_locked);
    wire freeze_now = limit_en && main_freq_at_limit;

    // Output assignments
    assign cpu_rdata                  = rdata_q;
    assign host_port_control_reg      = port_ctrl_q;
    assign input1_format_sel          = in_fmt_q[`BIT_IN1_FMT];
    assign diff_input_b_format        = in_fmt_q[`BIT_DIFF_B_FMT];
    assign diff_input_a_format        = in_fmt_q[`BIT_DIFF_A_FMT];
    assign synth_a_rate_khz           = rate_a_q;
    assign synth_b_rate_khz           = rate_b_q;
    assign composite_out_tone_en      = out_fmt_q[`BIT_TONE_EN];
    assign composite_out_frame_dis    = out_fmt_q[`BIT_FRAME_DIS];
    assign diff_out_b_en              = |out_fmt_q[`MSB_OUT_B:`LSB_OUT_B];
    assign diff_out_a_en              = |out_fmt_q[`MSB_OUT_A:`LSB_OUT_A];
    assign main_bw_sel                = want_acq ? BW_ACQ : BW_LOCKED;
    assign integral_freeze            = freeze_now;
    // Readback hold tracks the freeze so software sees the frozen value
    assign current_freq_readback_hold = freeze_now;
    // Test override wins over the select bit
    assign phase_detector_mode        = (!phase_detector_test_override
                                         && loop_q[`BIT_PD_SEL])
                                        ? PD_PFD : PD_NEAREST;

    // Checks, all in the ref_clk domain
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_status_read;
        cpu_rd_en && hit_status;
    endsequence

    sequence s_clear_limit;
        wr_loop && !cpu_wdata[`BIT_LIMIT_EN];
    endsequence

    sequence s_held_run;
        resetn ##1 resetn;
    endsequence

    // Three reset edges let the unreset synchronisers settle first
    sequence s_reset_held;
        !resetn [*3];
    endsequence

    a_status_live: assert property (
        s_status_read |=> cpu_rdata == {5'h00, $past(sel_sync_q)})
        else $error("status read does not show select pins");

    a_ctrl_capture: assert property (disable iff (1'b0)
        s_reset_held |=> host_port_control_reg == $past(sel_sync_q))
        else $error("port control not captured in reset");

    a_ctrl_hold: assert property (disable iff (1'b0)
        s_held_run |-> $stable(host_port_control_reg))
        else $error("port control moved after reset");

    a_family_strap: assert property (disable iff (1'b0)
        s_reset_held |=> fam_a == $past(fam_sync_q) && fam_b == $past(fam_sync_q))
        else $error("family bits not loaded from strap");

    a_alt_rate: assert property (
        alt_b |=> synth_b_rate_khz == 15'h18a8)
        else $error("alternate rate not 6312 kHz");

    a_rate_a_top: assert property (
        fam_a && !alt_b && mult_a == 2'b11 |=> synth_a_rate_khz == 15'h3040)
        else $error("synthesizer A top rate wrong");

    a_rate_b_sdh: assert property (
        !fam_b && !alt_b && mult_b == 2'b10 |=> synth_b_rate_khz == 15'h2000)
        else $error("synthesizer B sdh rate wrong");

    a_slave_acq: assert property (
        !prim_sync_q |-> main_bw_sel == BW_ACQ)
        else $error("slave mode not on acquisition bandwidth");

    a_auto_off: assert property (
        prim_sync_q && !auto_bw |-> main_bw_sel == BW_LOCKED)
        else $error("auto bandwidth off but not locked bandwidth");

    a_freeze_clear: assert property (
        s_clear_limit |=> !integral_freeze && !current_freq_readback_hold)
        else $error("freeze present with limit disabled");

    a_freeze_set: assert property (
        limit_en && main_freq_at_limit |-> current_freq_readback_hold)
        else $error("readback not held at limit");

    a_out_b_off: assert property (
        wr_out_fmt && cpu_wdata[3:2] == 2'b00 |=> !diff_out_b_en)
        else $error("output B not disabled by code 00");

    a_out_a_on: assert property (
        wr_out_fmt && cpu_wdata[1:0] != 2'b00 |=> diff_out_a_en)
        else $error("output A not enabled");

    a_diff_store: assert property (
        wr_in_fmt |=> diff_input_b_format == $past(cpu_wdata[1])
                      && diff_input_a_format == $past(cpu_wdata[0]))
        else $error("diff input format not stored");

    a_tone_en: assert property (
        wr_out_fmt |=> composite_out_tone_en == $past(cpu_wdata[5])
                       && composite_out_frame_dis == $past(cpu_wdata[4]))
        else $error("composite output bits not stored");

    a_pd_override: assert property (
        phase_detector_test_override |-> phase_detector_mode == PD_NEAREST)
        else $error("test override did not win");

    a_in1_store: assert property (
        wr_in_fmt |=> input1_format_sel == $past(cpu_wdata[`BIT_IN1_FMT]))
        else $error("input 1 format bit not stored");

    a_rate_b_sonet: assert property (
        fam_b && !alt_b && mult_b == 2'b00 |=> synth_b_rate_khz == 15'h0608)
        else $error("synthesizer B base rate wrong");

    a_rate_a_base: assert property (
        !fam_a && mult_a == 2'b00 |=> synth_a_rate_khz == 15'h0800)
        else $error("synthesizer A base rate wrong");

    a_rate_a_double: assert property (
        !fam_a && mult_a == 2'b01 |=> synth_a_rate_khz == 15'h1000)
        else $error("synthesizer A doubled rate wrong");

    a_mult_reset: assert property (disable iff (1'b0)
        !resetn |=> mult_a == 2'b00)
        else $error("synthesizer A multiple not reset");

    a_out_b_on: assert property (
        wr_out_fmt && cpu_wdata[3:2] != 2'b00 |=> diff_out_b_en)
        else $error("output B not enabled");

    a_out_a_off: assert property (
        wr_out_fmt && cpu_wdata[1:0] == 2'b00 |=> !diff_out_a_en)
        else $error("output A not disabled by code 00");

    a_auto_locked: assert property (
        prim_sync_q && auto_bw && main_pll_locked |-> main_bw_sel == BW_LOCKED)
        else $error("auto bandwidth locked but not locked bandwidth");

    a_auto_acq: assert property (
        prim_sync_q && auto_bw && !main_pll_locked |-> main_bw_sel == BW_ACQ)
        else $error("auto bandwidth unlocked but not acquisition");

    a_pd_select: assert property (
        !phase_detector_test_override && loop_q[`BIT_PD_SEL] |-> phase_detector_mode == PD_PFD)
        else $error("detector select bit ignored");

    a_freeze_limit: assert property (
        limit_en && main_freq_at_limit |-> integral_freeze)
        else $error("integral path not frozen at limit");

    a_freeze_off: assert property (
        !main_freq_at_limit |-> !integral_freeze && !current_freq_readback_hold)
        else $error("freeze present away from limit");

endmodule
`default_nettype wire

//--- include/timing_cfg_regs.svh
// Offsets, field positions, reset values and rate constants of the
// timing-card configuration register slice.
// Assumes an 8-bit processor port with byte-wide registers.
// Overview of operation
// - Bit 2 picks composite or CMOS input 1
// - Diff input format bits stored, no effect
// - Status field shows live select pins, rest zero
// - Select pins captured into control during reset
// - Select pins ignored by control after reset
// - Alternate bit gives synthesizer B 6312 kHz
// - Synthesizer B family picks 2048 or 1544 base
// - Synthesizer A family picks 2048 or 1544 base
// - Family bits load from strap during reset
// - Synthesizer B multiple gives one to eight times
// - Synthesizer A multiple bits 5:4, resets 00
// - Tone bit adds 400 Hz to composite output
// - Frame disable bit removes 8 kHz component
// - Output B code 00 disables, else LVDS
// - Output A code 00 disables, else LVDS
// - Auto bandwidth bit picks locked or automatic
// - Slave strap forces acquisition bandwidth
// - Limit bit freezes integral path at limits
// - Frequency readback held while integral frozen
// - Detector select bit, ignored under test override
`ifndef TIMING_CFG_REGS_SVH
`define TIMING_CFG_REGS_SVH

// Register offsets on the processor port
`define ADDR_INPUT_FORMAT   8'h36
`define ADDR_PORT_STATUS    8'h37
`define ADDR_SYNTH_FAMILY   8'h38
`define ADDR_SYNTH_MULT     8'h39
`define ADDR_OUTPUT_FORMAT  8'h3a
`define ADDR_DPLL_LOOP      8'h3b

// Reset values; family bits of the family register come from the strap
`define RST_INPUT_FORMAT    8'h02
`define RST_SYNTH_FAMILY    8'h1f
`define RST_SYNTH_MULT      8'h08
`define RST_OUTPUT_FORMAT   8'hc6
`define RST_DPLL_LOOP       8'hfb

// Field positions
`define BIT_IN1_FMT         2
`define BIT_DIFF_B_FMT      1
`define BIT_DIFF_A_FMT      0
`define BIT_B_ALT           7
`define BIT_B_FAMILY        6
`define BIT_A_FAMILY        5
`define MSB_B_MULT          7
`define LSB_B_MULT          6
`define MSB_A_MULT          5
`define LSB_A_MULT          4
`define BIT_TONE_EN         5
`define BIT_FRAME_DIS       4
`define MSB_OUT_B           3
`define LSB_OUT_B           2
`define MSB_OUT_A           1
`define LSB_OUT_A           0
`define BIT_AUTO_BW         7
`define BIT_LIMIT_EN        3
`define BIT_PD_SEL          2

// Synthesizer rates in kHz
`define RATE_SONET_KHZ      15'h0608
`define RATE_SDH_KHZ        15'h0800
`define RATE_ALT_KHZ        15'h18a8

`endif

//--- include/timing_cfg_pkg.sv
// Types shared by the timing-card configuration register slice.
// Assumes the constants header supplies all offsets and values.
package timing_cfg_pkg;

    // Bandwidth choice handed to the main loop
    typedef enum logic [0:0] {
        BW_LOCKED = 1'b0,
        BW_ACQ    = 1'b1
    } bandwidth_e;

    // Phase detector kind
    typedef enum logic [0:0] {
        PD_NEAREST = 1'b0,
        PD_PFD     = 1'b1
    } phase_det_e;

    typedef logic [7:0]  byte_t;
    typedef logic [14:0] rate_khz_t;

endpackage

//--- test/tb.sv
// Self-checking bench for the timing-card configuration register slice.
// Assumes reads answer one edge after the strobe, rates two edges after a write.
`timescale 1ns/1ps
`default_nettype none
`include "timing_cfg_regs.svh"

module tb;
    import timing_cfg_pkg::*;

    typedef struct {logic [7:0] addr; byte_t wdata; byte_t rdata;} row_s;

    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    logic [7:0] cpu_addr = 8'h00;
    byte_t      cpu_wdata = 8'h00;
    logic       cpu_wr_en = 1'b0;
    logic       cpu_rd_en = 1'b0;
    logic [7:0] cpu_rdata;
    logic [2:0] host_port_select_pins = 3'h5;
    logic       network_family_strap = 1'b0;
    logic       primary_backup_strap = 1'b1;
    logic       main_pll_locked = 1'b0;
    logic       main_freq_at_limit = 1'b0;
    logic       phase_detector_test_override = 1'b0;
    logic [2:0] host_port_control_reg;
    logic       input1_format_sel;
    logic       diff_input_b_format;
    logic       diff_input_a_format;
    rate_khz_t  synth_a_rate_khz;
    rate_khz_t  synth_b_rate_khz;
    logic       composite_out_tone_en;
    logic       composite_out_frame_dis;
    logic       diff_out_a_en;
    logic       diff_out_b_en;
    bandwidth_e main_bw_sel;
    logic       integral_freeze;
    logic       current_freq_readback_hold;
    phase_det_e phase_detector_mode;
    int         fail_count = 0;
    int         check_count = 0;
    row_s       rows[6];
    byte_t      rd_val;
    rate_khz_t  exp_rate;
    logic [6:0] v;

    // Half-period toggle gives the 50 ns system clock
    always #25 ref_clk = ~ref_clk;

    timing_card_config_regs dut_u (
        .ref_clk                      (ref_clk),
        .resetn                       (resetn),
        .cpu_addr                     (cpu_addr),
        .cpu_wdata                    (cpu_wdata),
        .cpu_wr_en                    (cpu_wr_en),
        .cpu_rd_en                    (cpu_rd_en),
        .cpu_rdata                    (cpu_rdata),
        .host_port_select_pins        (host_port_select_pins),
        .network_family_strap         (network_family_strap),
        .primary_backup_strap         (primary_backup_strap),
        .main_pll_locked              (main_pll_locked),
        .main_freq_at_limit           (main_freq_at_limit),
        .phase_detector_test_override (phase_detector_test_override),
        .host_port_control_reg        (host_port_control_reg),
        .input1_format_sel            (input1_format_sel),
        .diff_input_b_format          (diff_input_b_format),
        .diff_input_a_format          (diff_input_a_format),
        .synth_a_rate_khz             (synth_a_rate_khz),
        .synth_b_rate_khz             (synth_b_rate_khz),
        .composite_out_tone_en        (composite_out_tone_en),
        .composite_out_frame_dis      (composite_out_frame_dis),
        .diff_out_a_en                (diff_out_a_en),
        .diff_out_b_en                (diff_out_b_en),
        .main_bw_sel                  (main_bw_sel),
        .integral_freeze              (integral_freeze),
        .current_freq_readback_hold   (current_freq_readback_hold),
        .phase_detector_mode          (phase_detector_mode)
    );

    // Compare tasks, one per kind of result
    task automatic chk8(input byte_t got, input byte_t exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk15(input rate_khz_t got, input rate_khz_t exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe; released at the edge that samples it
    task automatic wr(input logic [7:0] a, input byte_t d);
        @(posedge ref_clk);
        cpu_addr  <= a;
        cpu_wdata <= d;
        cpu_wr_en <= 1'b1;
        @(posedge ref_clk);
        cpu_wr_en <= 1'b0;
    endtask

    // Read data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [7:0] a, output byte_t d);
        @(posedge ref_clk);
        cpu_addr  <= a;
        cpu_rd_en <= 1'b1;
        @(posedge ref_clk);
        cpu_rd_en <= 1'b0;
        @(posedge ref_clk);
        #1;
        d = cpu_rdata;
    endtask

    // Four cycles low covers the two synchroniser stages plus capture
    task automatic do_reset();
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic check_defaults(input byte_t fam_val, input rate_khz_t base);
        chk15(synth_a_rate_khz, base);
        chk15(synth_b_rate_khz, base);
        chk1(diff_out_a_en, 1'b1);
        chk1(diff_out_b_en, 1'b1);
        chk1(composite_out_tone_en, 1'b0);
        chk1(composite_out_frame_dis, 1'b0);
        rd(`ADDR_INPUT_FORMAT, rd_val);
        chk8(rd_val, `RST_INPUT_FORMAT);
        rd(`ADDR_SYNTH_FAMILY, rd_val);
        chk8(rd_val, fam_val);
        rd(`ADDR_SYNTH_MULT, rd_val);
        chk8(rd_val, `RST_SYNTH_MULT);
        rd(`ADDR_OUTPUT_FORMAT, rd_val);
        chk8(rd_val, `RST_OUTPUT_FORMAT);
        rd(`ADDR_DPLL_LOOP, rd_val);
        chk8(rd_val, `RST_DPLL_LOOP);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog: the tests need about 900 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        $display("watchdog expired");
        end_sim();
    end

    initial begin
        // Reserved bits in the family, multiple and loop rows carry their reset values
        rows = '{'{8'h36, 8'hff, 8'h07}, '{8'h36, 8'h00, 8'h00}, '{8'h38, 8'h5f, 8'h5f},
                 '{8'h39, 8'hb8, 8'hb8}, '{8'h3b, 8'h77, 8'h77}, '{8'h40, 8'h55, 8'h00}};
        do_reset();
        check_defaults(8'h1f, `RATE_SDH_KHZ);
        // Select pins move after release; control must keep the captured value
        host_port_select_pins <= 3'h2;
        wr(`ADDR_PORT_STATUS, 8'hff);
        rd(`ADDR_PORT_STATUS, rd_val);
        chk8(rd_val, 8'h02);
        chk8({5'h00, host_port_control_reg}, 8'h05);
        $display("test reset_and_status done");
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rd_val);
            chk8(rd_val, rows[i].rdata);
        end
        $display("test register_rows done");
        wr(`ADDR_INPUT_FORMAT, 8'h04);
        #1;
        chk8({5'h00, input1_format_sel, diff_input_b_format, diff_input_a_format}, 8'h04);
        wr(`ADDR_INPUT_FORMAT, 8'h03);
        #1;
        chk8({5'h00, input1_format_sel, diff_input_b_format, diff_input_a_format}, 8'h03);
        $display("test input_format done");
        for (int f = 0; f < 2; f++) for (int m = 0; m < 4; m++) begin
            wr(`ADDR_SYNTH_FAMILY, {1'b0, f[0], f[0], 5'h1f});
            wr(`ADDR_SYNTH_MULT, {m[1:0], m[1:0], 4'h8});
            repeat (2) @(posedge ref_clk);
            #1;
            exp_rate = (f[0] ? `RATE_SONET_KHZ : `RATE_SDH_KHZ) << m;
            chk15(synth_b_rate_khz, exp_rate);
            chk15(synth_a_rate_khz, exp_rate);
        end
        wr(`ADDR_SYNTH_FAMILY, 8'h9f);
        wr(`ADDR_SYNTH_MULT, 8'h08);
        repeat (2) @(posedge ref_clk);
        #1;
        chk15(synth_b_rate_khz, `RATE_ALT_KHZ);
        chk15(synth_a_rate_khz, `RATE_SDH_KHZ);
        $display("test synth_rates done");
        for (int c = 0; c < 4; c++) begin
            wr(`ADDR_OUTPUT_FORMAT, {2'b11, c[1:0], c[1:0], c[1:0]});
            #1;
            chk1(composite_out_tone_en, c[1]);
            chk1(composite_out_frame_dis, c[0]);
            chk1(diff_out_b_en, |c[1:0]);
            chk1(diff_out_a_en, |c[1:0]);
        end
        $display("test output_controls done");
        // Every mix of auto bit, strap, lock, limit, detector and override
        for (int i = 0; i < 128; i++) begin
            v = i[6:0];
            @(posedge ref_clk);
            primary_backup_strap         <= v[1];
            main_pll_locked              <= v[2];
            main_freq_at_limit           <= v[4];
            phase_detector_test_override <= v[6];
            wr(`ADDR_DPLL_LOOP, {v[0], 3'h7, v[3], v[5], 2'b11});
            repeat (3) @(posedge ref_clk);
            #1;
            chk1(main_bw_sel, ~v[1] | (v[0] & ~v[2]));
            chk1(integral_freeze, v[3] & v[4]);
            chk1(current_freq_readback_hold, v[3] & v[4]);
            chk1(phase_detector_mode, v[5] & ~v[6]);
        end
        $display("test dpll_loop done");
        // Second reset with the other strap level and new select pins
        network_family_strap  <= 1'b1;
        primary_backup_strap  <= 1'b1;
        host_port_select_pins <= 3'h6;
        do_reset();
        check_defaults(8'h7f, `RATE_SONET_KHZ);
        chk8({5'h00, host_port_control_reg}, 8'h06);
        $display("test second_reset done");
        end_sim();
    end
endmodule
`default_nettype wire
